// [bench/opp_programmer_asserts.sv]
// Purpose: Port checks for the PROM programming controller.
// Assumes: Bound with the programmer's own parameters.
// Notes: Strobe widths are counted in ref_clk cycles.
`default_nettype none
module opp_programmer_asserts
   import opp_pkg::*;
#(
   parameter int unsigned PULSE_CYC = 20,
   parameter logic [16:0] FIRST_ADDR = 17'h01000,
   parameter logic [16:0] LAST_ADDR = 17'h01003
) (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic [7:0] imageData,
   input wire opp_pins_t pins,
   input wire logic busy,
   input wire logic fail
);
   timeunit 1ns;
   timeprecision 1ps;
   int unsigned lowCnt;
   always_ff @(posedge ref_clk or negedge reset_n)
      if (!reset_n)
         lowCnt <= 0;
      else
         lowCnt <= pins.program_strobe_n ? 0 : lowCnt + 1;
   default clocking @(posedge ref_clk);
   endclocking
   default disable iff (!reset_n);
   chk_prog_set: assert property ($fell(pins.program_strobe_n) |->
      !pins.chipSelect_n && pins.outputEnable_n && pins.vppHigh
      && pins.vccHigh && !pins.deviceReset_n) else $error("bad strobe set");
   chk_data_held: assert property (!pins.program_strobe_n |->
      pins.dataOe && pins.dataOut == imageData) else $error("data lost");
   chk_pulse_len: assert property ($rose(pins.program_strobe_n) |->
      lowCnt != 0 && lowCnt % PULSE_CYC == 0) else $error("pulse width");
   chk_addr_span: assert property (!pins.chipSelect_n |->
      pins.addr >= FIRST_ADDR && pins.addr <= LAST_ADDR) else $error("span");
   chk_addr_step: assert property ($changed(pins.addr) &&
      !pins.chipSelect_n |-> pins.addr == $past(pins.addr) + 17'h1)
      else $error("address step");
   chk_read_safe: assert property (!pins.outputEnable_n |->
      !pins.dataOe && pins.program_strobe_n) else $error("read clash");
   chk_idle_quiet: assert property (!busy [*2] |->
      pins.program_strobe_n && !pins.dataOe) else $error("idle strobe");
   chk_fail_stop: assert property ($rose(fail) |=>
      (!busy && pins.program_strobe_n) [*4]) else $error("fail runs on");
   cover property ($rose(fail));
   cover property ($rose(pins.program_strobe_n) && lowCnt > PULSE_CYC);
   cover property ($fell(pins.outputEnable_n));
endmodule : opp_programmer_asserts
bind opp_programmer opp_programmer_asserts #(.PULSE_CYC(PULSE_CYC),
   .FIRST_ADDR(FIRST_ADDR), .LAST_ADDR(LAST_ADDR)) i_chk (.ref_clk(ref_clk),
   .reset_n(reset_n), .imageData(imageData), .pins(pins), .busy(busy),
   .fail(fail));
`default_nettype wire

// [bench/opp_prom_model.sv]
// Purpose: Behavioural PROM behind the programming port.
// Assumes: A byte sticks after need strobes at one address.
// Notes: Unread data pins show the inverse of the last byte.
`default_nettype none
module opp_prom_model
   import opp_pkg::*;
(
   input wire opp_pins_t pins,
   input wire logic [7:0] need,
   output logic [7:0] dataPins
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] mem [16];
   logic [7:0] hits = 8'h00;
   logic [16:0] hitAddr = 17'h00000;
   logic [7:0] last = 8'h00;
   always @(negedge pins.program_strobe_n) begin
      if (!pins.deviceReset_n && !pins.chipSelect_n
            && pins.outputEnable_n && pins.vppHigh) begin
         hits = (pins.addr == hitAddr) ? hits + 8'h01 : 8'h01;
         hitAddr = pins.addr;
         if (hits >= need)
            mem[pins.addr[3:0]] = pins.dataOut;
      end
   end
   always @* begin
      if (!pins.chipSelect_n && !pins.outputEnable_n) begin
         dataPins = mem[pins.addr[3:0]];
         last = dataPins;
      end else
         dataPins = ~last;
   end
endmodule : opp_prom_model
`default_nettype wire

// [bench/tb_opp_programmer.sv]
// Purpose: Self-checking bench for the PROM programming controller.
// Assumes: Shortened pulse, setup, tries and address span.
// Notes: Rows give strobes needed per byte, image key, failure.
`default_nettype none
module tb_opp_programmer
   import opp_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct {logic [7:0] need; logic [7:0] key; logic bad;} opp_row_t;
   opp_row_t rows [3] = '{'{8'h01, 8'h5a, 1'b0}, '{8'h03, 8'ha5, 1'b0},
      '{8'h1e, 8'h3c, 1'b1}};
   logic ref_clk = 1'b0;
   logic reset_n = 1'b0;
   logic start = 1'b0;
   logic [7:0] need = 8'h01;
   logic [7:0] key = 8'h00;
   logic [16:0] imageAddr;
   logic [7:0] promDataIn;
   opp_pins_t pins;
   logic busy, done, fail, mismatch;
   int n_fail = 0;
   int samples_checked = 0;
   int lowCyc = 0;
   always #2 ref_clk = ~ref_clk;
   always @(posedge ref_clk)
      lowCyc <= lowCyc + int'(!pins.program_strobe_n);
   opp_programmer #(.PULSE_CYC(20), .SETUP_CYC(4), .FIRST_ADDR(17'h01000),
      .LAST_ADDR(17'h01003), .MAX_TRIES(4)) i_dut (.ref_clk(ref_clk),
      .reset_n(reset_n), .start(start), .imageData(key ^ imageAddr[7:0]),
      .imageAddr(imageAddr), .promDataIn(promDataIn), .pins(pins),
      .busy(busy), .done(done), .fail(fail), .mismatch(mismatch));
   opp_prom_model i_mod (.pins(pins), .need(need), .dataPins(promDataIn));
   task automatic check(input string what, input logic [31:0] seen, exp);
      samples_checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic stop_test;
      $display("checked %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : stop_test
   initial begin
      repeat (2) @(negedge ref_clk);
      reset_n = 1'b1;
      check("idle strobe", pins.program_strobe_n, 1'b1);
      check("idle mode", pins.deviceReset_n, 1'b1);
      repeat (2) @(negedge ref_clk);
      foreach (rows[r]) begin
         need = rows[r].need;
         key = rows[r].key;
         lowCyc = 0;
         start = 1'b1;
         @(negedge ref_clk);
         start = 1'b0;
         for (int n = 0; n < 20000 && (busy !== 1'b0 || n < 4); n++)
            @(negedge ref_clk);
         check("fail", fail, rows[r].bad);
         if (!rows[r].bad) begin
            check("done", done, 1'b1);
            check("final read", mismatch, 1'b0);
            check("strobe cycles", lowCyc, 160 * rows[r].need);
            for (int a = 0; a < 4; a++)
               check("byte", i_mod.mem[a], rows[r].key ^ a[7:0]);
         end
         $display("row %0d finished", r);
      end
      repeat (8) @(negedge ref_clk);
      start = 1'b1;
      repeat (30) @(negedge ref_clk);
      check("busy", busy, 1'b1);
      start = 1'b0;
      reset_n = 1'b0;
      @(negedge ref_clk);
      check("reset select", pins.chipSelect_n, 1'b1);
      check("reset supply", pins.vppHigh, 1'b0);
      reset_n = 1'b1;
      $display("reset test finished");
      stop_test();
   end
   // Runs need well under 20 us; ten times that marks a hang
   initial begin
      #200us;
      n_fail++;
      stop_test();
   end
endmodule : tb_opp_programmer
`default_nettype wire

// [core/opp_params.svh]
// Purpose: Constants for the parallel PROM programmer controller.
// Assumes: ref_clk at 250 MHz (4 ns period).
// Notes: Times are kept in their printed unit; cycle counts derive from them.
// Summary of operation
// RULE1: The device is in programming mode only while its reset pin is low.
// RULE2: Only addresses 0x01000 through 0x1ffff are programmed by default.
// RULE3: With chip select and output enable low the device drives the byte.
// RULE4: With chip select and output enable high the data pins float.
// RULE5: Programming needs chip select low, output enable high, supply raised.
// RULE6: A low program strobe writes the applied byte to the address.
// RULE7: Programming starts at 0x01000 with core 6 V and supply 12.5 V.
// RULE8: Each try is one 0.2 ms strobe pulse followed by a read-back check.
// RULE9: Tries repeat until the read-back matches, counting the pulses.
// RULE10: After a match an extra stimulus of count times 0.2 ms is applied.
// RULE11: Each extra strobe pulse lasts between 0.19 ms and 5.25 ms.
// RULE12: The address then increments until the last address is done.
// RULE13: After the last address the contents are read back at 5 V supplies; the code reads back only the byte at the last address.
// RULE14: Strobe activity outside programming conditions changes nothing.
`ifndef OPP_PARAMS_SVH
`define OPP_PARAMS_SVH
`define OPP_CLK_MHZ 250
`define OPP_FIRST_ADDR 17'h01000
`define OPP_LAST_ADDR 17'h1ffff
`define OPP_PULSE_US 200
`define OPP_PULSE_CYC (`OPP_PULSE_US * `OPP_CLK_MHZ)
`define OPP_SETUP_US 2
`define OPP_SETUP_CYC (`OPP_SETUP_US * `OPP_CLK_MHZ)
`define OPP_OE_NS 150
`define OPP_OE_CYC ((`OPP_OE_NS * `OPP_CLK_MHZ + 999) / 1000)
`define OPP_MAX_TRIES 25
`endif

// [core/opp_pkg.sv]
// Purpose: Types for the parallel PROM programmer controller.
// Assumes: Constants come from opp_params.svh.
// Notes: Pin group travels as one packed struct.
`default_nettype none
package opp_pkg;
   typedef enum logic [9:0] {
      OPP_IDLE   = 10'h001,
      OPP_POWER  = 10'h002,
      OPP_SETUP  = 10'h004,
      OPP_PULSE  = 10'h008,
      OPP_RELAX  = 10'h010,
      OPP_VERIFY = 10'h020,
      OPP_EXTRA  = 10'h040,
      OPP_NEXT   = 10'h080,
      OPP_FINAL  = 10'h100,
      OPP_DONE   = 10'h200
   } opp_state_t;
   typedef struct packed {
      logic [16:0] addr;
      logic [7:0] dataOut;
      logic dataOe;
      logic chipSelect_n;
      logic outputEnable_n;
      logic program_strobe_n;
      logic vppHigh;
      logic vccHigh;
      logic deviceReset_n;
   } opp_pins_t;
endpackage : opp_pkg
`default_nettype wire

// [core/opp_programmer.sv]
// Purpose: Drives a byte-wide PROM port through pulse-and-verify programming.
// Assumes: Image bytes arrive on request; data pins sampled on ref_clk.
// Notes: Long counts are parameters so a simulation can shorten them.
`include "opp_params.svh"
`default_nettype none
module opp_programmer
   import opp_pkg::*;
#(
   parameter int unsigned PULSE_CYC = `OPP_PULSE_CYC,
   parameter int unsigned SETUP_CYC = `OPP_SETUP_CYC,
   parameter logic [16:0] FIRST_ADDR = `OPP_FIRST_ADDR,
   parameter logic [16:0] LAST_ADDR = `OPP_LAST_ADDR,
   parameter int unsigned MAX_TRIES = `OPP_MAX_TRIES
) (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic start,
   input wire logic [7:0] imageData,
   output logic [16:0] imageAddr,
   input wire logic [7:0] promDataIn,
   output opp_pins_t pins,
   output logic busy,
   output logic done,
   output logic fail,
   output logic mismatch
);
   localparam int unsigned OE_CYC = `OPP_OE_CYC;
   localparam int CW = 32;
   logic rstMeta, rst_n;
   opp_state_t state, next_state;
   logic [CW-1:0] timer;
   logic [7:0] tries, extraLeft;
   logic timerDone;
   // One flop per pin; the struct output is only their bundle
   logic [16:0] pinAddr;
   logic [7:0] pinData;
   logic pinDataOe;
   logic pinSelect_n;
   logic pinOutEn_n;
   logic pinStrobe_n;
   logic pinVpp;
   logic pinVcc;
   logic pinReset_n;
   logic next_supply;

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         rstMeta <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rstMeta <= 1'b1;
         rst_n <= rstMeta;
      end
   end

   assign timerDone = (timer == '0);

   always_comb begin
      next_state = state;
      case (state)
         OPP_IDLE: if (start) next_state = OPP_POWER;
         OPP_POWER: if (timerDone) next_state = OPP_SETUP;
         OPP_SETUP: if (timerDone) next_state = OPP_PULSE;
         OPP_PULSE: if (timerDone) next_state = OPP_RELAX;
         OPP_RELAX: if (timerDone) next_state = OPP_VERIFY;
         OPP_VERIFY: begin
            if (timerDone) begin
               if (promDataIn == imageData) next_state = OPP_EXTRA;
               else if (tries >= 8'(MAX_TRIES)) next_state = OPP_DONE;
               else next_state = OPP_SETUP;
            end
         end
         OPP_EXTRA: if (timerDone && extraLeft <= 8'h01) next_state = OPP_NEXT;
         OPP_NEXT: begin
            if (timerDone) begin
               if (imageAddr == LAST_ADDR) next_state = OPP_FINAL;
               else next_state = OPP_SETUP;
            end
         end
         OPP_FINAL: if (timerDone) next_state = OPP_DONE;
         OPP_DONE: if (start) next_state = OPP_POWER;
         default: next_state = OPP_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) state <= OPP_IDLE;
      else state <= next_state;
   end

   // Timer reloads on every state change; program pulses are exact 0.2 ms, the extra pulse tries times that
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         timer <= '0;
      end else if (next_state != state ||
            (state == OPP_EXTRA && timerDone)) begin
         case (next_state)
            OPP_PULSE, OPP_EXTRA: timer <= CW'(PULSE_CYC - 1); // RULE8 RULE11
            OPP_VERIFY: timer <= CW'(OE_CYC);
            default: timer <= CW'(SETUP_CYC - 1);
         endcase
      end else if (!timerDone) begin
         timer <= timer - 1'b1;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         imageAddr <= FIRST_ADDR;
         tries <= 8'h00;
         extraLeft <= 8'h00;
      end else begin
         if (state == OPP_IDLE || state == OPP_DONE) begin
            imageAddr <= FIRST_ADDR; // RULE2 RULE7
         end else if (state == OPP_NEXT && timerDone &&
               imageAddr != LAST_ADDR) begin
            imageAddr <= imageAddr + 17'h00001; // RULE12
         end
         if (state == OPP_NEXT || state == OPP_POWER) tries <= 8'h00;
         else if (state == OPP_PULSE && timerDone) tries <= tries + 8'h01; // RULE9
         if (state == OPP_VERIFY && next_state == OPP_EXTRA) begin
            extraLeft <= tries; // RULE10
         end else if (state == OPP_EXTRA && timerDone) begin
            extraLeft <= extraLeft - 8'h01;
         end
      end
   end

   // Supplies stay raised from power-up until the last byte is done or a byte fails
   assign next_supply = next_state inside {OPP_POWER, OPP_SETUP, OPP_PULSE,
      OPP_RELAX, OPP_VERIFY, OPP_EXTRA, OPP_NEXT};

   // Address and data follow the image byte being programmed
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         pinAddr <= 17'h00000;
         pinData <= 8'h00;
      end else begin
         pinAddr <= imageAddr;
         pinData <= imageData; // RULE6
      end
   end

   // Device held in programming mode whenever a run is active
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         pinReset_n <= 1'b1;
      end else begin
         pinReset_n <= (next_state == OPP_IDLE); // RULE1
      end
   end

   // Supply levels; low means the plain read level
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         pinVpp <= 1'b0;
         pinVcc <= 1'b0;
      end else begin
         pinVpp <= next_supply; // RULE5 RULE7 RULE13
         pinVcc <= next_supply; // RULE7
      end
   end

   // Select is released while idle, powering up or finished
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         pinSelect_n <= 1'b1;
      end else begin
         pinSelect_n <= next_state inside {OPP_IDLE, OPP_POWER,
            OPP_DONE}; // RULE5
      end
   end

   // Output enable low only for read-back; high floats the device pins
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         pinOutEn_n <= 1'b1;
      end else begin
         pinOutEn_n <= !(next_state == OPP_VERIFY ||
            next_state == OPP_FINAL); // RULE3 RULE4 RULE5
      end
   end

   // Data drive only while the device is not driving back
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         pinDataOe <= 1'b0;
      end else begin
         pinDataOe <= next_state inside {OPP_SETUP, OPP_PULSE,
            OPP_EXTRA}; // RULE6
      end
   end

   // Strobe low only in pulse states, where select and supply are set
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         pinStrobe_n <= 1'b1;
      end else begin
         pinStrobe_n <= !(next_state == OPP_PULSE ||
            next_state == OPP_EXTRA); // RULE6 RULE14
      end
   end

   always_comb begin
      pins.addr = pinAddr;
      pins.dataOut = pinData;
      pins.dataOe = pinDataOe;
      pins.chipSelect_n = pinSelect_n;
      pins.outputEnable_n = pinOutEn_n;
      pins.program_strobe_n = pinStrobe_n;
      pins.vppHigh = pinVpp;
      pins.vccHigh = pinVcc;
      pins.deviceReset_n = pinReset_n;
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         busy <= 1'b0;
      end else begin
         busy <= !(next_state == OPP_IDLE || next_state == OPP_DONE);
      end
   end

   // Completion flags; setting wins over a start in the same cycle
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         done <= 1'b0;
         mismatch <= 1'b0;
      end else if (state == OPP_FINAL && timerDone) begin
         done <= 1'b1;
         mismatch <= (promDataIn != imageData); // RULE13
      end else if (start) begin
         done <= 1'b0;
         mismatch <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         fail <= 1'b0;
      end else if (state == OPP_VERIFY && next_state == OPP_DONE) begin
         fail <= 1'b1;
      end else if (start) begin
         fail <= 1'b0;
      end
   end
endmodule : opp_programmer
`default_nettype wire
